// *** rtl/sysid_pkg.sv ***
// constants for the system id, key and band gap register bank
// assumes an apb slave on a 250 mhz core clock with synchronous reset
package sysid_pkg;
  // ------------------------------------------------------------
  // register byte addresses (apb address bits used: 15:0)
  // ------------------------------------------------------------
  localparam logic [15:0] CFG_CONTROL_OFFS  = 16'h3b00; // configuration control low bits
  localparam logic [15:0] DEV_ID_OFFS       = 16'h3b20; // identification word
  localparam logic [15:0] UNLOCK_KEY_OFFS   = 16'h3b30; // write-only key
  localparam logic [15:0] BANDGAP_OFFS      = 16'h2300; // band gap control base
  localparam logic [15:0] CLEAR_ALIAS_OFFS  = 16'h0004; // clear alias distance
  localparam logic [15:0] SET_ALIAS_OFFS    = 16'h0008; // set alias distance
  localparam logic [15:0] INVERT_ALIAS_OFFS = 16'h000c; // invert alias distance
  localparam logic [15:0] HW_REQ_OFFS       = 16'h2310; // hardware request status, read only

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int REV_LSB      = 28; // revision_field 31:28
  localparam int PART_ID_LSB  = 0;  // part_identifier_field 27:0
  localparam int ADC_REF_BIT  = 2;  // adc_reference_enable
  localparam int CMP_REF_BIT  = 1;  // comparator_reference_enable
  localparam int CFG_RSVD_LSB = 0;  // cfg control reserved 1:0
  localparam int CFG_DBG_BIT  = 3;  // debug port enable in cfg control

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] KEY_RESET     = 32'h0000_0000; // key clears on reset
  localparam logic [1:0]  BANDGAP_RESET = 2'h0;          // both references off
  localparam logic [1:0]  CFG_RSVD_VAL  = 2'h3;          // reserved bits read as ones
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000; // unmapped read value

  // alias operation kinds
  typedef enum logic [1:0] {
    OP_WRITE  = 2'b00,
    OP_CLEAR  = 2'b01,
    OP_SET    = 2'b10,
    OP_INVERT = 2'b11
  } alias_op_t;
endpackage

// *** rtl/bandgap_bits.sv ***
// two reference enable bits with alias writes and hardware set/clear
// assumes one-cycle write strobes from the apb slave on the same clock
`timescale 1ns/1ps
module bandgap_bits (
  input  wire logic                 core_clk_in,   // core clock
  input  wire logic                 reset_in,      // sync reset, active high
  input  wire logic                 sw_we_in,      // software write strobe
  input  wire sysid_pkg::alias_op_t sw_op_in,      // plain, clear, set or invert
  input  wire logic [1:0]           sw_data_in,    // {adc, cmp} write data
  input  wire logic [1:0]           hw_set_in,     // hardware set pulses
  input  wire logic [1:0]           hw_clr_in,     // hardware clear pulses
  output logic      [1:0]           enables_out    // {adc, cmp} enables
);
  logic [1:0] bits_reg;  // current enables
  logic [1:0] bits_next; // value after this edge

  // ------------------------------------------------------------
  // next value: software first, then hardware on top
  // ------------------------------------------------------------
  always_comb begin
    bits_next = bits_reg;
    if (sw_we_in) begin
      // RL4: atomic alias ops
      case (sw_op_in)
        sysid_pkg::OP_CLEAR:  bits_next = bits_reg & ~sw_data_in;
        sysid_pkg::OP_SET:    bits_next = bits_reg | sw_data_in;
        sysid_pkg::OP_INVERT: bits_next = bits_reg ^ sw_data_in;
        default:              bits_next = sw_data_in;
      endcase
    end
    // RL10: hardware set and clear
    // set wins over clear so a set request is never lost
    bits_next = (bits_next & ~hw_clr_in) | hw_set_in;
  end

  // RL5: enables reset to zero
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      bits_reg <= sysid_pkg::BANDGAP_RESET;
    end else begin
      bits_reg <= bits_next;
    end
  end

  assign enables_out = bits_reg;

  // hardware set must show one edge later
  hw_set_seen_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL10
    hw_set_in[0] |=> bits_reg[0]) else $error("hardware set of cmp enable lost");
  hw_clr_seen_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL10
    (hw_clr_in[1] && !hw_set_in[1]) |=> !bits_reg[1]) else $error("hardware clear of adc enable lost");
endmodule // bandgap_bits

// *** rtl/sysid_regs.sv ***
// apb register bank: identification, unlock key, band gap control, cfg low bits
// assumes an apb master on core_clk_in; the analog requests come from same-clock logic
`timescale 1ns/1ps

// Notes on behaviour
// RL1: id word: revision 31:28, identifier 27:0
// RL2: id fields are per-variant constant parameters
// RL3: key is 32-bit write-only, resets zero
// RL4: clear, set, invert aliases at +4/+8/+c
// RL5: band gap resets zero, unused bits zero
// RL6: cfg control bit 2 reads zero
// RL7: software writes ones to cfg bits 1:0
// RL8: bit 2 enables adc reference
// RL9: bit 1 enables comparator reference
// RL10: enables software rw, hardware set/clear
// RL11: key register reads back as zero
module sysid_regs #(
  parameter logic [3:0]  REVISION = 4'h1,        // arbitrary value, set per variant
  parameter logic [27:0] PART_ID  = 28'h000_0a5a // arbitrary value, set per variant
) (
  input  wire logic        core_clk_in,      // core clock, 250 mhz
  input  wire logic        reset_in,         // sync reset, active high
  input  wire logic        psel_in,          // apb select
  input  wire logic        penable_in,       // apb enable
  input  wire logic        pwrite_in,        // apb direction, high for write
  input  wire logic [15:0] paddr_in,         // apb byte address
  input  wire logic [31:0] pwdata_in,        // apb write data
  input  wire logic [3:0]  pstrb_in,         // apb byte strobes
  input  wire logic [1:0]  ref_set_req_in,   // {adc, cmp} hardware set pulses
  input  wire logic [1:0]  ref_clr_req_in,   // {adc, cmp} hardware clear pulses
  input  wire logic        dbg_port_strap_in,// debug enable strap, sampled at reset
  output logic      [31:0] prdata_out,       // apb read data
  output logic             pready_out,       // apb ready
  output logic             pslverr_out,      // apb error on unmapped address
  output logic             adc_ref_en_out,   // adc reference enable
  output logic             cmp_ref_en_out,   // comparator reference enable
  output logic      [31:0] unlock_key_out,   // last key written, for the lock logic
  output logic             key_write_out     // one-cycle pulse on each key write
);
  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  logic        access;        // setup seen, access phase now
  logic        wr_acc;        // write in access phase
  logic [31:0] strb_mask;     // byte mask from strobes
  logic        hit_cfg;       // cfg control selected
  logic        hit_id;        // identification selected
  logic        hit_key;       // key selected
  logic        hit_bg;        // band gap base or alias selected
  logic        hit_req;       // hardware request mirror selected
  logic        mapped;        // any register selected
  sysid_pkg::alias_op_t bg_op; // which band gap alias

  // single-wait-state slave: ready goes high one cycle into the access phase
  assign access = psel_in && penable_in && !pready_out;
  assign wr_acc = access && pwrite_in;
  assign strb_mask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

  // address decoding
  always_comb begin
    hit_cfg = 1'b0;
    hit_id  = 1'b0;
    hit_key = 1'b0;
    hit_bg  = 1'b0;
    hit_req = 1'b0;
    bg_op   = sysid_pkg::OP_WRITE;
    if (paddr_in == sysid_pkg::CFG_CONTROL_OFFS) begin
      hit_cfg = 1'b1;
    end else if (paddr_in == sysid_pkg::DEV_ID_OFFS) begin
      hit_id = 1'b1;
    end else if (paddr_in == sysid_pkg::UNLOCK_KEY_OFFS) begin
      hit_key = 1'b1;
    end else if (paddr_in == sysid_pkg::BANDGAP_OFFS) begin
      hit_bg = 1'b1;
    end else if (paddr_in == sysid_pkg::BANDGAP_OFFS + sysid_pkg::CLEAR_ALIAS_OFFS) begin
      // RL4: clear alias
      hit_bg = 1'b1;
      bg_op  = sysid_pkg::OP_CLEAR;
    end else if (paddr_in == sysid_pkg::BANDGAP_OFFS + sysid_pkg::SET_ALIAS_OFFS) begin
      // RL4: set alias
      hit_bg = 1'b1;
      bg_op  = sysid_pkg::OP_SET;
    end else if (paddr_in == sysid_pkg::BANDGAP_OFFS + sysid_pkg::INVERT_ALIAS_OFFS) begin
      // RL4: invert alias
      hit_bg = 1'b1;
      bg_op  = sysid_pkg::OP_INVERT;
    end else if (paddr_in == sysid_pkg::HW_REQ_OFFS) begin
      hit_req = 1'b1;
    end
  end
  assign mapped = hit_cfg | hit_id | hit_key | hit_bg | hit_req;

  // ------------------------------------------------------------
  // strap capture: two flops, then held after release until software writes cfg bit 3
  // ------------------------------------------------------------
  logic strap_s1_reg;   // first sync flop
  logic strap_s2_reg;   // second sync flop
  logic dbg_en_reg;     // debug enable bit of cfg control

  always_ff @(posedge core_clk_in) begin
    strap_s1_reg <= dbg_port_strap_in;
    strap_s2_reg <= strap_s1_reg;
  end

  // follows the strap while in reset, software may change it after
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      dbg_en_reg <= strap_s2_reg;
    end else if (wr_acc && hit_cfg && pstrb_in[0]) begin
      dbg_en_reg <= pwdata_in[sysid_pkg::CFG_DBG_BIT];
    end
  end

  // ------------------------------------------------------------
  // unlock key
  // ------------------------------------------------------------
  logic [31:0] key_reg;       // stored key
  logic        key_pulse_reg; // write pulse

  // RL3: key write-only storage
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      key_reg <= sysid_pkg::KEY_RESET;
    end else if (wr_acc && hit_key) begin
      key_reg <= (key_reg & ~strb_mask) | (pwdata_in & strb_mask);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      key_pulse_reg <= 1'b0;
    end else begin
      key_pulse_reg <= wr_acc && hit_key;
    end
  end
  assign unlock_key_out = key_reg;
  assign key_write_out  = key_pulse_reg;

  // ------------------------------------------------------------
  // band gap enables
  // ------------------------------------------------------------
  logic [1:0] bg_bits; // {adc, cmp}

  // RL8: adc enable on bit 2
  // RL9: comparator enable on bit 1
  bandgap_bits u_bandgap (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .sw_we_in    (wr_acc && hit_bg && pstrb_in[0]),
    .sw_op_in    (bg_op),
    .sw_data_in  ({pwdata_in[sysid_pkg::ADC_REF_BIT], pwdata_in[sysid_pkg::CMP_REF_BIT]}),
    .hw_set_in   (ref_set_req_in),
    .hw_clr_in   (ref_clr_req_in),
    .enables_out (bg_bits)
  );
  assign adc_ref_en_out = bg_bits[1];
  assign cmp_ref_en_out = bg_bits[0];

  // set pulses of the last hardware request, readable for debug
  logic [1:0] last_req_reg;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      last_req_reg <= 2'h0;
    end else if (|(ref_set_req_in | ref_clr_req_in)) begin
      last_req_reg <= ref_set_req_in;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [31:0] rd_word; // selected read value
  always_comb begin
    rd_word = sysid_pkg::ZERO_WORD;
    if (hit_id) begin
      // RL1: revision and identifier fields
      // RL2: variant constants
      rd_word = {REVISION, PART_ID};
    end else if (hit_key) begin
      // RL11: key reads zero
      rd_word = sysid_pkg::ZERO_WORD;
    end else if (hit_bg) begin
      // RL5: unused bits zero
      rd_word[sysid_pkg::ADC_REF_BIT] = bg_bits[1];
      rd_word[sysid_pkg::CMP_REF_BIT] = bg_bits[0];
    end else if (hit_cfg) begin
      // RL6: bit 2 reads zero; RL7: reserved bits shown as ones
      rd_word[1:0] = sysid_pkg::CFG_RSVD_VAL;
      rd_word[sysid_pkg::CFG_DBG_BIT] = dbg_en_reg;
    end else if (hit_req) begin
      rd_word[1:0] = last_req_reg;
    end
  end

  // ------------------------------------------------------------
  // answer: all bus outputs from flops
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= sysid_pkg::ZERO_WORD;
    end else begin
      pready_out  <= access;
      pslverr_out <= access && !mapped;
      prdata_out  <= (access && !pwrite_in) ? rd_word : sysid_pkg::ZERO_WORD;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence bg_set_write_s;
    wr_acc && (paddr_in == sysid_pkg::BANDGAP_OFFS + sysid_pkg::SET_ALIAS_OFFS)
      && pstrb_in[0] && pwdata_in[sysid_pkg::ADC_REF_BIT] && !ref_clr_req_in[1];
  endsequence

  id_read_value_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL1
    (access && !pwrite_in && hit_id) |=> (prdata_out == {REVISION, PART_ID} && pready_out))
    else $error("id word read wrong");
  key_read_zero_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL11
    (access && !pwrite_in && hit_key) |=> prdata_out == sysid_pkg::ZERO_WORD)
    else $error("key read not zero");
  key_write_store_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL3
    (wr_acc && hit_key && pstrb_in == 4'hf) |=> (key_reg == $past(pwdata_in) && key_write_out))
    else $error("key not stored");
  set_alias_adc_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL4
    bg_set_write_s |=> adc_ref_en_out) else $error("set alias failed");
  bg_read_mask_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL5
    (access && !pwrite_in && hit_bg) |=> prdata_out[31:3] == 29'h0 && prdata_out[0] == 1'b0)
    else $error("band gap unused bits set");
  cfg_bit2_zero_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL6
    (access && !pwrite_in && hit_cfg) |=> prdata_out[2] == 1'b0) else $error("cfg bit 2 not zero");
  adc_bit_read_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL8
    (access && !pwrite_in && hit_bg) |=> prdata_out[2] == $past(adc_ref_en_out))
    else $error("adc bit read mismatch");
  cmp_bit_read_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // RL9
    (access && !pwrite_in && hit_bg) |=> prdata_out[1] == $past(cmp_ref_en_out))
    else $error("cmp bit read mismatch");
  ready_one_wait_a : assert property (@(posedge core_clk_in) disable iff (reset_in) // one wait state: ready one cycle after access, low the next
    access |=> pready_out ##1 !pready_out) else $error("ready timing wrong");
endmodule // sysid_regs

// *** dv/sysid_regs_bench.sv ***
// self-checking bench for the id, unlock key and band gap register bank
// assumes the apb slave answers within sixteen cycles; the strap is raised only for the second reset
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module sysid_regs_bench;
  // ------------------------------------------------------------
  // variant constants and stimulus signals
  // ------------------------------------------------------------
  localparam logic [3:0]  REV = 4'h3;         // arbitrary value, variant revision
  localparam logic [27:0] PID = 28'h0123456;  // arbitrary value, variant identifier
  localparam logic [15:0] BG  = sysid_pkg::BANDGAP_OFFS; // band gap base
  logic        core_clk_in;      // core clock
  logic        reset_in;         // sync reset
  logic        psel;             // apb select
  logic        penable;          // apb enable
  logic        pwrite;           // apb direction
  logic [15:0] paddr;            // apb address
  logic [31:0] pwdata;           // apb write data
  logic [3:0]  pstrb;            // apb byte strobes
  logic [1:0]  set_req;          // hardware set pulses
  logic [1:0]  clr_req;          // hardware clear pulses
  logic        strap;            // debug enable strap pin
  int          key_pulses = 0;   // key write pulses seen at falling edges
  logic [31:0] prdata_out;       // read data
  logic        pready_out;       // ready
  logic        pslverr_out;      // error
  logic        adc_ref_en_out;   // adc reference enable
  logic        cmp_ref_en_out;   // comparator reference enable
  logic [31:0] unlock_key_out;   // stored key
  logic        key_write_out;    // key write pulse
  int          failures;         // mismatches seen
  int          samples_checked;  // comparisons made

  sysid_regs #(.REVISION(REV), .PART_ID(PID)) i_dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .ref_set_req_in(set_req), .ref_clr_req_in(clr_req), .dbg_port_strap_in(strap),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .adc_ref_en_out(adc_ref_en_out), .cmp_ref_en_out(cmp_ref_en_out),
    .unlock_key_out(unlock_key_out), .key_write_out(key_write_out));

  // 250 mhz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  // count key write pulses mid-cycle, where they are settled; the pulse
  // falls before the bus task returns, so the scenario cannot poll for it
  always @(negedge core_clk_in) begin
    if (key_write_out === 1'b1) key_pulses++;
  end

  // ------------------------------------------------------------
  // bus and helper tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk_in); n++; end while (pready_out !== 1'b1 && n < 16);
    // a slave that never answers ends the run
    if (pready_out !== 1'b1) begin failures++; report_and_stop(); end
    else begin r = prdata_out; e = pslverr_out; psel <= 1'b0; penable <= 1'b0; end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] r, output logic e);
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  // one-cycle hardware request, then one edge for the enable to land
  task automatic hw(input logic [1:0] s, input logic [1:0] c);
    @(posedge core_clk_in); set_req <= s; clr_req <= c;
    @(posedge core_clk_in); set_req <= 2'h0; clr_req <= 2'h0;
    @(posedge core_clk_in);
  endtask

  task automatic do_reset();
    @(posedge core_clk_in); reset_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    logic [31:0] r; logic e;
    rd(BG, r, e); `CHECK(r, 32'h0000_0000)
    `CHECK({adc_ref_en_out, cmp_ref_en_out}, 2'h0)
    rd(sysid_pkg::DEV_ID_OFFS, r, e); `CHECK(r, {REV, PID})
    `CHECK(r[31:28], REV)
    wr(sysid_pkg::DEV_ID_OFFS, 32'hffff_ffff);
    rd(sysid_pkg::DEV_ID_OFFS, r, e); `CHECK(r, {REV, PID})
    rd(sysid_pkg::UNLOCK_KEY_OFFS, r, e); `CHECK(r, 32'h0000_0000)
    rd(sysid_pkg::CFG_CONTROL_OFFS, r, e); `CHECK(r, 32'h0000_0003)
    rd(16'h1000, r, e); `CHECK({e, r}, {1'b1, 32'h0000_0000})
  endtask

  task automatic t_key();
    logic [31:0] r; logic e; int pulses;
    pulses = key_pulses;
    wr(sysid_pkg::UNLOCK_KEY_OFFS, 32'h1234_5678);
    // pulse must show exactly once for one key write
    repeat (2) @(posedge core_clk_in);
    `CHECK(key_pulses - pulses, 1)
    `CHECK(unlock_key_out, 32'h1234_5678)
    rd(sysid_pkg::UNLOCK_KEY_OFFS, r, e); `CHECK(r, 32'h0000_0000)
    pstrb <= 4'h1;
    wr(sysid_pkg::UNLOCK_KEY_OFFS, 32'hffff_ffff);
    pstrb <= 4'hf;
    repeat (2) @(posedge core_clk_in);
    `CHECK(unlock_key_out, 32'h1234_56ff)
  endtask

  task automatic t_alias();
    logic [31:0] r; logic e;
    wr(BG, 32'h0000_0006);
    rd(BG, r, e); `CHECK(r, 32'h0000_0006)
    `CHECK({adc_ref_en_out, cmp_ref_en_out}, 2'h3)
    wr(BG + sysid_pkg::CLEAR_ALIAS_OFFS, 32'h0000_0004);
    rd(BG, r, e); `CHECK(r, 32'h0000_0002)
    `CHECK(adc_ref_en_out, 1'b0)
    wr(BG + sysid_pkg::SET_ALIAS_OFFS, 32'h0000_0004);
    rd(BG, r, e); `CHECK(r, 32'h0000_0006)
    wr(BG + sysid_pkg::INVERT_ALIAS_OFFS, 32'h0000_0002);
    rd(BG, r, e); `CHECK(r, 32'h0000_0004)
    `CHECK(cmp_ref_en_out, 1'b0)
    wr(BG, 32'hffff_ffff);
    rd(BG, r, e); `CHECK(r, 32'h0000_0006)
    wr(BG, 32'h0000_0000);
  endtask

  task automatic t_hw();
    logic [31:0] r; logic e;
    hw(2'h1, 2'h0); `CHECK({adc_ref_en_out, cmp_ref_en_out}, 2'h1)
    hw(2'h0, 2'h1); `CHECK(cmp_ref_en_out, 1'b0)
    hw(2'h2, 2'h2); `CHECK(adc_ref_en_out, 1'b1)
    rd(sysid_pkg::HW_REQ_OFFS, r, e); `CHECK(r, 32'h0000_0002)
    rd(BG, r, e); `CHECK(r, 32'h0000_0004)
    hw(2'h0, 2'h2); `CHECK(adc_ref_en_out, 1'b0)
    wr(BG, 32'h0000_0002);
    rd(BG, r, e); `CHECK(r, 32'h0000_0002)
  endtask

  task automatic t_cfg();
    logic [31:0] r; logic e;
    wr(sysid_pkg::CFG_CONTROL_OFFS, 32'h0000_000f);
    rd(sysid_pkg::CFG_CONTROL_OFFS, r, e); `CHECK(r, 32'h0000_000b)
    wr(sysid_pkg::CFG_CONTROL_OFFS, 32'h0000_0007);
    rd(sysid_pkg::CFG_CONTROL_OFFS, r, e); `CHECK(r, 32'h0000_0003)
  endtask

  task automatic t_reset_again();
    logic [31:0] r; logic e;
    wr(BG, 32'h0000_0006);
    // strap high through reset: debug enable must load from it
    strap <= 1'b1;
    do_reset();
    rd(BG, r, e); `CHECK(r, 32'h0000_0000)
    rd(sysid_pkg::CFG_CONTROL_OFFS, r, e); `CHECK(r, 32'h0000_000b)
    `CHECK(unlock_key_out, 32'h0000_0000)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0; samples_checked = 0;
    reset_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 16'h0000; pwdata = 32'h0000_0000; pstrb = 4'hf;
    set_req = 2'h0; clr_req = 2'h0; strap = 1'b0;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    t_reset_values();
    t_key();
    t_alias();
    t_hw();
    t_cfg();
    t_reset_again();
    report_and_stop();
  end
endmodule // sysid_regs_bench
